// ==== common/trxsc_pkg.sv ====
// Constants, types and register map of the transceiver state and calibration
// block. Assumes a single 40 MHz system clock and a host register port.
package trxsc_pkg;
  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned T_TRANS_NS = 2000;
  localparam int unsigned T_CAL_NS = 1000;
  localparam int unsigned T_RECOV_NS = 500;
  localparam logic [7:0] TRANS_CYC =
    8'((T_TRANS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] CAL_CYC =
    8'((T_CAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] RECOV_CYC =
    8'((T_RECOV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [3:0] ADDR_STATE = 4'h0;
  localparam logic [3:0] ADDR_CMD = 4'h1;
  localparam logic [3:0] ADDR_SYNTH = 4'h2;
  localparam logic [3:0] ADDR_CHAN = 4'h3;
  localparam logic [3:0] ADDR_CAL_I = 4'h4;
  localparam logic [3:0] ADDR_CAL_Q = 4'h5;
  localparam logic [3:0] ADDR_IRQ_EN = 4'h6;

  localparam logic [2:0] CMD_OFF = 3'h2;
  localparam logic [2:0] CMD_TXPREP = 3'h3;
  localparam logic [2:0] CMD_RX = 3'h5;
  localparam logic [2:0] CODE_OFF = 3'h2;
  localparam logic [2:0] CODE_TXPREP = 3'h3;
  localparam logic [2:0] CODE_RX = 3'h5;
  localparam logic [2:0] CODE_TRANS = 3'h7;

  localparam logic [7:0] SYNTH_ARM = 8'h09;
  localparam logic [7:0] SYNTH_FIRE = 8'h08;
  localparam logic [6:0] RST_SYNTH = 7'h08;
  localparam int unsigned CAL_W = 6;
  localparam logic [5:0] RST_CAL = 6'h20;
  localparam logic [7:0] RST_CHAN = 8'h00;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    FSM_OFF, FSM_TRANS, FSM_TXPREP, FSM_RX, FSM_CHAN
  } trxsc_fsm_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } trxsc_req_t;

  typedef struct packed {
    logic [CAL_W-1:0] i;
    logic [CAL_W-1:0] q;
  } trxsc_iq_t;
endpackage

// ==== hw/trxsc_cal.sv ====
// LO leakage calibration loop: captures the measured I/Q offsets after a
// fixed settle time. Assumes start is a one-cycle pulse.
`timescale 1ns/1ps
`default_nettype none
module trxsc_cal (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic start,
  input wire trxsc_pkg::trxsc_iq_t meas_iq,
  output logic busy,
  output logic done,
  output trxsc_pkg::trxsc_iq_t result
);
  typedef struct packed {
    logic busy;
    logic done;
    logic [7:0] cnt;
    trxsc_pkg::trxsc_iq_t result;
  } trxsc_cal_st_t;

  trxsc_cal_st_t state_reg;
  trxsc_cal_st_t state_next;

  always_comb begin
    state_next = state_reg;
    state_next.done = 1'b0;
    if (start) begin
      state_next.busy = 1'b1;
      state_next.cnt = trxsc_pkg::CAL_CYC;
    end else if (state_reg.busy) begin
      if (state_reg.cnt == 8'h01) begin
        state_next.busy = 1'b0;
        state_next.done = 1'b1;
        state_next.result = meas_iq;
      end
      state_next.cnt = 8'(state_reg.cnt - 8'h01);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign busy = state_reg.busy;
  assign done = state_reg.done;
  assign result = state_reg.result;
endmodule
`default_nettype wire

// ==== hw/trxsc_top.sv ====
// Transceiver state machine with automatic calibration when leaving off for transmit-prepare or receive, channel
// change, stuck-transition model and synthesizer recovery.
// Assumes host register accesses are synchronous to clk_sys.
`timescale 1ns/1ps
`default_nettype none
module trxsc_top (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire trxsc_pkg::trxsc_req_t reg_req,
  input wire logic trx_fault,
  input wire trxsc_pkg::trxsc_iq_t meas_iq,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic ready_interrupt,
  output logic synth_lock_flag,
  output trxsc_pkg::trxsc_iq_t cal_iq
);
  typedef struct packed {
    trxsc_pkg::trxsc_fsm_t fsm;
    logic target_rx;
    logic stuck;
    logic armed;
    logic [7:0] cnt;
    logic [5:0] cal_i;
    logic [5:0] cal_q;
    logic [6:0] synth;
    logic lock;
    logic irq_en;
    logic [7:0] chan;
    logic [7:0] rd_data;
    logic rd_valid;
    logic irq;
  } trxsc_st_t;

  trxsc_st_t state_reg;
  trxsc_st_t state_next;
  logic cal_start;
  logic cal_busy;
  logic cal_done;
  trxsc_pkg::trxsc_iq_t cal_result;
  logic wr_cmd;
  logic wr_chan;
  logic [2:0] state_code;

  // ****************************************************************
  // Calibration loop
  // ****************************************************************
  trxsc_cal u_cal (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .start(cal_start),
    .meas_iq(meas_iq),
    .busy(cal_busy),
    .done(cal_done),
    .result(cal_result)
  );

  assign wr_cmd = reg_req.wr && (reg_req.addr == trxsc_pkg::ADDR_CMD);
  assign wr_chan = reg_req.wr && (reg_req.addr == trxsc_pkg::ADDR_CHAN);

  // ****************************************************************
  // State machine and registers
  // ****************************************************************
  always_comb begin
    state_next = state_reg;
    state_next.irq = 1'b0;
    state_next.rd_valid = 1'b0;
    cal_start = 1'b0;
    if (state_reg.cnt != 8'h00) begin
      state_next.cnt = 8'(state_reg.cnt - 8'h01);
    end
    case (state_reg.fsm)
      trxsc_pkg::FSM_OFF: begin
        if (wr_cmd && (reg_req.wdata[2:0] == trxsc_pkg::CMD_TXPREP ||
            reg_req.wdata[2:0] == trxsc_pkg::CMD_RX)) begin
          state_next.fsm = trxsc_pkg::FSM_TRANS;
          state_next.target_rx = reg_req.wdata[2:0] == trxsc_pkg::CMD_RX;
          state_next.stuck = trx_fault;
          state_next.cnt = trxsc_pkg::TRANS_CYC;
          state_next.lock = 1'b0;
          cal_start = 1'b1;
        end
      end
      trxsc_pkg::FSM_TRANS: begin
        if (cal_done) begin
          state_next.cal_i = cal_result.i;
          state_next.cal_q = cal_result.q;
        end
        if (!state_reg.stuck && state_reg.cnt == 8'h00 && !cal_busy) begin
          state_next.fsm = state_reg.target_rx ? trxsc_pkg::FSM_RX :
                           trxsc_pkg::FSM_TXPREP;
          state_next.lock = 1'b1;
          state_next.irq = !state_reg.target_rx && state_reg.irq_en;
        end
      end
      trxsc_pkg::FSM_TXPREP: begin
        if (wr_cmd && reg_req.wdata[2:0] == trxsc_pkg::CMD_RX) begin
          state_next.fsm = trxsc_pkg::FSM_RX;
        end else if (wr_chan) begin
          state_next.fsm = trxsc_pkg::FSM_CHAN;
          state_next.lock = 1'b0;
          state_next.stuck = trx_fault;
          state_next.cnt = trxsc_pkg::TRANS_CYC;
        end
      end
      trxsc_pkg::FSM_CHAN: begin
        if (!state_reg.stuck && state_reg.cnt == 8'h00) begin
          state_next.fsm = trxsc_pkg::FSM_TXPREP;
          state_next.lock = 1'b1;
          state_next.irq = state_reg.irq_en;
        end
      end
      trxsc_pkg::FSM_RX: begin
        if (wr_cmd && reg_req.wdata[2:0] == trxsc_pkg::CMD_TXPREP) begin
          state_next.fsm = trxsc_pkg::FSM_TXPREP;
        end
      end
      default: begin
        state_next.fsm = trxsc_pkg::FSM_OFF;
      end
    endcase
    // Host writes
    if (reg_req.wr) begin
      if (reg_req.addr == trxsc_pkg::ADDR_SYNTH) begin
        state_next.synth = reg_req.wdata[6:0];
        if (reg_req.wdata == trxsc_pkg::SYNTH_ARM) begin
          state_next.armed = 1'b1;
        end else if (reg_req.wdata == trxsc_pkg::SYNTH_FIRE &&
                     state_reg.armed) begin
          state_next.armed = 1'b0;
          if (state_reg.fsm == trxsc_pkg::FSM_TRANS ||
              state_reg.fsm == trxsc_pkg::FSM_CHAN) begin
            state_next.stuck = 1'b0;
            state_next.cnt = trxsc_pkg::RECOV_CYC;
          end
        end
      end else if (reg_req.addr == trxsc_pkg::ADDR_CAL_I) begin
        state_next.cal_i = reg_req.wdata[5:0];
      end else if (reg_req.addr == trxsc_pkg::ADDR_CAL_Q) begin
        state_next.cal_q = reg_req.wdata[5:0];
      end else if (reg_req.addr == trxsc_pkg::ADDR_IRQ_EN) begin
        state_next.irq_en = reg_req.wdata[0];
      end else if (reg_req.addr == trxsc_pkg::ADDR_CHAN) begin
        state_next.chan = reg_req.wdata;
      end
    end
    if (wr_cmd && reg_req.wdata[2:0] == trxsc_pkg::CMD_OFF) begin
      state_next.fsm = trxsc_pkg::FSM_OFF;
      state_next.stuck = 1'b0;
      state_next.armed = 1'b0;
      state_next.lock = 1'b0;
      state_next.cnt = 8'h00;
    end
    // Host reads
    if (reg_req.rd) begin
      state_next.rd_valid = 1'b1;
      if (reg_req.addr == trxsc_pkg::ADDR_STATE) begin
        state_next.rd_data = {5'h00, state_code};
      end else if (reg_req.addr == trxsc_pkg::ADDR_SYNTH) begin
        state_next.rd_data = {state_reg.lock, state_reg.synth};
      end else if (reg_req.addr == trxsc_pkg::ADDR_CHAN) begin
        state_next.rd_data = state_reg.chan;
      end else if (reg_req.addr == trxsc_pkg::ADDR_CAL_I) begin
        state_next.rd_data = {2'b00, state_reg.cal_i};
      end else if (reg_req.addr == trxsc_pkg::ADDR_CAL_Q) begin
        state_next.rd_data = {2'b00, state_reg.cal_q};
      end else if (reg_req.addr == trxsc_pkg::ADDR_IRQ_EN) begin
        state_next.rd_data = {7'h00, state_reg.irq_en};
      end else begin
        state_next.rd_data = 8'h00;
      end
    end
  end

  always_comb begin
    case (state_reg.fsm)
      trxsc_pkg::FSM_OFF: state_code = trxsc_pkg::CODE_OFF;
      trxsc_pkg::FSM_TXPREP: state_code = trxsc_pkg::CODE_TXPREP;
      trxsc_pkg::FSM_RX: state_code = trxsc_pkg::CODE_RX;
      default: state_code = trxsc_pkg::CODE_TRANS;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state_reg <= '0;
      state_reg.fsm <= trxsc_pkg::FSM_OFF;
      state_reg.synth <= trxsc_pkg::RST_SYNTH;
      state_reg.cal_i <= trxsc_pkg::RST_CAL;
      state_reg.cal_q <= trxsc_pkg::RST_CAL;
      state_reg.chan <= trxsc_pkg::RST_CHAN;
    end else begin
      state_reg <= state_next;
    end
  end

  assign rd_data = state_reg.rd_data;
  assign rd_valid = state_reg.rd_valid;
  assign ready_interrupt = state_reg.irq;
  assign synth_lock_flag = state_reg.lock;
  assign cal_iq = {state_reg.cal_i, state_reg.cal_q};

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_cal_store: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (cal_done && state_reg.fsm == trxsc_pkg::FSM_TRANS && !reg_req.wr)
    |=> (state_reg.cal_i == $past(cal_result.i)) &&
        (state_reg.cal_q == $past(cal_result.q)))
    else $error("calibration result not stored");
  chk_cal_field: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (reg_req.rd && reg_req.addr == trxsc_pkg::ADDR_CAL_I)
    |=> rd_valid && rd_data == {2'b00, $past(state_reg.cal_i)})
    else $error("calibration field readback wrong");
  chk_rx_path: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (state_reg.fsm == trxsc_pkg::FSM_OFF && wr_cmd &&
     reg_req.wdata[2:0] == trxsc_pkg::CMD_RX)
    |=> state_reg.fsm == trxsc_pkg::FSM_TRANS && cal_busy)
    else $error("receive path skipped calibration");
  chk_ready_irq: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (state_reg.fsm == trxsc_pkg::FSM_TXPREP &&
     $past(state_reg.fsm) == trxsc_pkg::FSM_TRANS)
    |-> ready_interrupt == $past(state_reg.irq_en) && synth_lock_flag)
    else $error("ready interrupt wrong on reaching transmit-prepare");
  chk_trans_code: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (state_reg.fsm == trxsc_pkg::FSM_TRANS && reg_req.rd &&
     reg_req.addr == trxsc_pkg::ADDR_STATE)
    |-> !ready_interrupt ##1 rd_data == {5'h00, trxsc_pkg::CODE_TRANS})
    else $error("transition state not reported");
  chk_chan_lock: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (state_reg.fsm == trxsc_pkg::FSM_TXPREP &&
     $past(state_reg.fsm) == trxsc_pkg::FSM_CHAN)
    |-> synth_lock_flag && ready_interrupt == $past(state_reg.irq_en))
    else $error("channel change completion wrong");
  chk_cal_write: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (reg_req.wr && reg_req.addr == trxsc_pkg::ADDR_CAL_Q)
    |=> cal_iq.q == $past(reg_req.wdata[5:0]))
    else $error("host calibration write lost");
endmodule
`default_nettype wire

// ==== dv/trxsc_host.sv ====
// Host model: register strobes, state polling and synthesizer recovery.
// Assumes the one-cycle strobe register port of the transceiver block.
`timescale 1ns/1ps
`default_nettype none
module trxsc_host (
  input wire logic clk_sys,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid,
  output trxsc_pkg::trxsc_req_t reg_req
);
  // ****************************************************************
  // Register access and recovery
  // ****************************************************************
  initial reg_req = '0;

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_req <= '{1'b1, 1'b0, a, d};
    @(posedge clk_sys);
    reg_req <= '0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d,
    output bit ok);
    int n;
    @(posedge clk_sys);
    reg_req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk_sys);
    reg_req <= '0;
    ok = 1'b0;
    d = 8'h00;
    for (n = 0; n < 4 && !ok; n++) begin
      @(negedge clk_sys);
      if (rd_valid === 1'b1) begin
        ok = 1'b1;
        d = rd_data;
      end
    end
  endtask

  task automatic wait_state(input logic [2:0] t, input time lim,
    output bit ok);
    time t0;
    logic [7:0] v;
    bit r;
    t0 = $time;
    ok = 1'b0;
    while (!ok && ($time - t0) < lim) begin
      rd(trxsc_pkg::ADDR_STATE, v, r);
      ok = r && (v[2:0] === t);
    end
  endtask

  task automatic recover(input logic [2:0] t, output bit ok);
    int k;
    ok = 1'b0;
    for (k = 0; k < 3 && !ok; k++) begin
      wr(trxsc_pkg::ADDR_SYNTH, trxsc_pkg::SYNTH_ARM);
      repeat (20000 / trxsc_pkg::CLK_PERIOD_NS) @(posedge clk_sys);
      wr(trxsc_pkg::ADDR_SYNTH, trxsc_pkg::SYNTH_FIRE);
      wait_state(t, 20000, ok);
    end
  endtask
endmodule
`default_nettype wire

// ==== dv/test_trxsc_top.sv ====
// Testbench: drives the transceiver block through the host model and
// checks reads, interrupts, lock flag and applied calibration values.
`timescale 1ns/1ps
`default_nettype none
module test_trxsc_top;
  // ****************************************************************
  // Signals, monitors and helpers
  // ****************************************************************
  logic clk_sys, rst_b, trx_fault, rd_valid, ready_interrupt;
  logic synth_lock_flag;
  logic [7:0] rd_data, note;
  trxsc_pkg::trxsc_req_t reg_req;
  trxsc_pkg::trxsc_iq_t meas_iq, cal_iq;
  int num_errors = 0;
  int checked = 0;
  int irq_cnt = 0;
  int n0, r, n;
  bit ok;
  logic [31:0] rng = 32'h27;
  logic [5:0] vi[5], vq[5], mi, mq;
  logic [7:0] note_q[$];

  trxsc_top DUT (.clk_sys(clk_sys), .rst_b(rst_b), .reg_req(reg_req),
    .trx_fault(trx_fault), .meas_iq(meas_iq), .rd_data(rd_data),
    .rd_valid(rd_valid), .ready_interrupt(ready_interrupt),
    .synth_lock_flag(synth_lock_flag), .cal_iq(cal_iq));
  trxsc_host host (.clk_sys(clk_sys), .rd_data(rd_data),
    .rd_valid(rd_valid), .reg_req(reg_req));

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (ready_interrupt === 1'b1) irq_cnt <= irq_cnt + 1;
  end
  always @(negedge clk_sys) begin
    if (rd_valid === 1'b1 && note_q.size() > 0) begin
      note = note_q.pop_front();
      check("read data", rd_data, note);
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s;
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  function automatic logic [5:0] med5(input logic [29:0] p);
    logic [5:0] a;
    int lt;
    int le;
    med5 = p[5:0];
    for (int i = 0; i < 5; i++) begin
      a = p[6*i +: 6];
      lt = 0;
      le = 0;
      for (int j = 0; j < 5; j++) begin
        if (p[6*j +: 6] < a) lt++;
        if (p[6*j +: 6] <= a) le++;
      end
      if (lt <= 2 && le >= 3) med5 = a;
    end
  endfunction

  task automatic check(input string what, input logic [7:0] seen,
    input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic stall();
    num_errors++;
    $display("mismatch wait expected done seen timeout");
    finish_test();
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] v;
    bit k;
    note_q.push_back(e);
    host.rd(a, v, k);
    if (!k) stall();
  endtask
  task automatic go(input logic [2:0] t);
    bit k;
    host.wait_state(t, 200000, k);
    if (!k) stall();
    repeat (2) @(posedge clk_sys);
  endtask
  task automatic cmd(input logic [2:0] c);
    host.wr(trxsc_pkg::ADDR_CMD, {5'h00, c});
  endtask
  task automatic new_meas(output logic [5:0] ei, output logic [5:0] eq);
    rng = xs(rng);
    @(posedge clk_sys);
    meas_iq <= rng[11:0];
    ei = rng[11:6];
    eq = rng[5:0];
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    rst_b = 1'b0;
    trx_fault = 1'b0;
    meas_iq = '0;
    repeat (6) @(posedge clk_sys);
    rst_b <= 1'b1;
    rd_chk(trxsc_pkg::ADDR_CAL_I, {2'b00, trxsc_pkg::RST_CAL});
    rd_chk(trxsc_pkg::ADDR_CAL_Q, {2'b00, trxsc_pkg::RST_CAL});
    rd_chk(trxsc_pkg::ADDR_STATE, {5'h00, trxsc_pkg::CODE_OFF});
    rd_chk(4'hf, 8'h00);
    host.wr(trxsc_pkg::ADDR_IRQ_EN, 8'h01);
    rd_chk(trxsc_pkg::ADDR_IRQ_EN, 8'h01);
    $display("test reset done");
    for (r = 0; r < 5; r++) begin
      new_meas(vi[r], vq[r]);
      host.wr(trxsc_pkg::ADDR_IRQ_EN, {7'h00, r != 1});
      n0 = irq_cnt;
      cmd(trxsc_pkg::CMD_TXPREP);
      rd_chk(trxsc_pkg::ADDR_STATE,
        {5'h00, trxsc_pkg::CODE_TRANS});
      go(trxsc_pkg::CODE_TXPREP);
      check("irq txprep", 8'(irq_cnt - n0), {7'h00, r != 1});
      rd_chk(trxsc_pkg::ADDR_CAL_I, {2'b00, vi[r]});
      rd_chk(trxsc_pkg::ADDR_CAL_Q, {2'b00, vq[r]});
      cmd(trxsc_pkg::CMD_OFF);
      go(trxsc_pkg::CODE_OFF);
    end
    mi = med5({vi[4], vi[3], vi[2], vi[1], vi[0]});
    mq = med5({vq[4], vq[3], vq[2], vq[1], vq[0]});
    $display("test calibration runs done");
    new_meas(vi[0], vq[0]);
    n0 = irq_cnt;
    cmd(trxsc_pkg::CMD_RX);
    go(trxsc_pkg::CODE_RX);
    check("irq rx", 8'(irq_cnt - n0), 8'h00);
    rd_chk(trxsc_pkg::ADDR_CAL_I, {2'b00, vi[0]});
    rd_chk(trxsc_pkg::ADDR_CAL_Q, {2'b00, vq[0]});
    host.wr(trxsc_pkg::ADDR_CAL_I, {2'b11, mi});
    host.wr(trxsc_pkg::ADDR_CAL_Q, {2'b11, mq});
    rd_chk(trxsc_pkg::ADDR_CAL_I, {2'b00, mi});
    check("cal_iq i", {2'b00, cal_iq.i}, {2'b00, mi});
    check("cal_iq q", {2'b00, cal_iq.q}, {2'b00, mq});
    $display("test receive and override done");
    cmd(trxsc_pkg::CMD_TXPREP);
    go(trxsc_pkg::CODE_TXPREP);
    rng = xs(rng);
    n0 = irq_cnt;
    host.wr(trxsc_pkg::ADDR_CHAN, rng[7:0]);
    @(negedge clk_sys);
    check("lock low", {7'h00, synth_lock_flag}, 8'h00);
    for (n = 0; n < 200 && irq_cnt == n0; n++) @(negedge clk_sys);
    check("irq chan", 8'(irq_cnt - n0), 8'h01);
    check("lock high", {7'h00, synth_lock_flag}, 8'h01);
    if (irq_cnt == n0) stall();
    rd_chk(trxsc_pkg::ADDR_SYNTH, 8'h88);
    rd_chk(trxsc_pkg::ADDR_CHAN, rng[7:0]);
    rd_chk(trxsc_pkg::ADDR_CAL_Q, {2'b00, mq});
    cmd(trxsc_pkg::CMD_RX);
    go(trxsc_pkg::CODE_RX);
    rd_chk(trxsc_pkg::ADDR_STATE, {5'h00, trxsc_pkg::CODE_RX});
    $display("test channel change done");
    new_meas(vi[1], vq[1]);
    cmd(trxsc_pkg::CMD_OFF);
    go(trxsc_pkg::CODE_OFF);
    @(posedge clk_sys);
    trx_fault <= 1'b1;
    n0 = irq_cnt;
    cmd(trxsc_pkg::CMD_TXPREP);
    @(posedge clk_sys);
    trx_fault <= 1'b0;
    host.wait_state(trxsc_pkg::CODE_TXPREP, 200000, ok);
    check("stuck reached", {7'h00, ok}, 8'h00);
    rd_chk(trxsc_pkg::ADDR_STATE, {5'h00, trxsc_pkg::CODE_TRANS});
    check("irq stuck", 8'(irq_cnt - n0), 8'h00);
    host.recover(trxsc_pkg::CODE_TXPREP, ok);
    repeat (2) @(posedge clk_sys);
    check("recovered", {7'h00, ok}, 8'h01);
    check("irq recovered", 8'(irq_cnt - n0), 8'h01);
    rd_chk(trxsc_pkg::ADDR_CAL_I, {2'b00, vi[1]});
    $display("test stuck recovery done");
    finish_test();
  end
endmodule
`default_nettype wire
